/* verilog/oprl_ports.sv */
`timescale 1ns/1ns
// Summary of operation
// - Four byte ports at base plus zero..three
// - Port address equals base plus offset
// - Idle opto input reads as one
// - Energized opto input reads as zero
// - Relay port reads complement of drive
// - Writes to input ports are ignored
// - One closes relay, zero opens it
// - Input port low bit zero is interrupt source
// - IRQ asserted on low, only where jumpered
// - Closed switch gives zero, open gives one
// - Base selectable from 100h to 3fch
module oprl_ports
	import oprl_pkg::*;
(
	input  wire logic        core_clk,             // ISA bus clock
	input  wire logic        reset,                // Bus reset, active high
	input  wire logic [9:0]  isa_addr,             // I/O address
	input  wire logic        isa_aen,              // DMA cycle, suppresses decode
	input  wire logic        isa_ior_n,            // I/O read strobe
	input  wire logic        isa_iow_n,            // I/O write strobe
	input  wire logic [7:0]  isa_data_in,          // Write data from bus
	output logic      [7:0]  isa_data_out,         // Read data to bus
	output logic             isa_data_oe,          // High while card drives data
	input  wire logic [7:0]  base_address_switch,  // Switch level, open is one
	input  wire logic [5:0]  interrupt_line_jumper,// One-hot IRQ 2/9..7 select
	input  wire logic [15:0] opto_led_on,          // High when an opto LED conducts
	output logic      [15:0] relay_energize,       // High closes relay
	output logic      [5:0]  isa_irq               // IRQ 2/9..7 request lines
);
	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	oprl_dec_if dif();
	assign dif.base_address_switch = base_address_switch;
	assign dif.addr                = isa_addr;

	oprl_decode u_dec (
		.dif (dif)
	);

	logic sel;
	assign sel = dif.hit && !isa_aen;

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [7:0]  relay_lo_reg, relay_lo_next;
	logic [7:0]  relay_hi_reg, relay_hi_next;
	logic [7:0]  data_out_reg, data_out_next;
	logic        data_oe_reg,  data_oe_next;
	logic [5:0]  irq_reg,      irq_next;
	logic        iow_n_reg,    iow_n_next;
	oprl_acc_t   acc_reg,      acc_next;
	logic [15:0] opto_port;

	// Optocoupler output pulls low when its LED is on
	assign opto_port = ~opto_led_on;

	always_comb begin
		relay_lo_next = relay_lo_reg;
		relay_hi_next = relay_hi_reg;
		data_out_next = OPRL_IDLE_DATA;
		data_oe_next  = 1'b0;
		iow_n_next    = isa_iow_n;
		acc_next      = acc_reg;

		// Write latches on the strobe's falling edge, once per cycle
		if (sel && !isa_iow_n && iow_n_reg) begin
			case (dif.offset)
				OPRL_OFF_RELAY_LO: relay_lo_next = isa_data_in;
				OPRL_OFF_RELAY_HI: relay_hi_next = isa_data_in;
				default: ;
			endcase
		end

		if (sel && !isa_ior_n) begin
			data_oe_next = 1'b1;
			acc_next     = OPRL_ACC_ACTIVE;
			case (dif.offset)
				OPRL_OFF_OPTO_LO:  data_out_next = opto_port[7:0];
				OPRL_OFF_OPTO_HI:  data_out_next = opto_port[15:8];
				OPRL_OFF_RELAY_LO: data_out_next = ~relay_lo_reg;
				OPRL_OFF_RELAY_HI: data_out_next = ~relay_hi_reg;
				default:           data_out_next = OPRL_IDLE_DATA;
			endcase
		end else begin
			acc_next = OPRL_ACC_IDLE;
		end

		// Level request while the source bit reads low, only on the jumpered line
		irq_next = opto_port[0] ? 6'h00 : interrupt_line_jumper;
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			relay_lo_reg <= OPRL_RELAY_RST;
			relay_hi_reg <= OPRL_RELAY_RST;
			data_out_reg <= OPRL_IDLE_DATA;
			data_oe_reg  <= 1'b0;
			irq_reg      <= 6'h00;
			iow_n_reg    <= 1'b1;
			acc_reg      <= OPRL_ACC_IDLE;
		end else begin
			relay_lo_reg <= relay_lo_next;
			relay_hi_reg <= relay_hi_next;
			data_out_reg <= data_out_next;
			data_oe_reg  <= data_oe_next;
			irq_reg      <= irq_next;
			iow_n_reg    <= iow_n_next;
			acc_reg      <= acc_next;
		end
	end

	assign isa_data_out   = data_out_reg;
	assign isa_data_oe    = data_oe_reg;
	assign relay_energize = {relay_hi_reg, relay_lo_reg};
	assign isa_irq        = irq_reg;
endmodule

/* pkg/oprl_pkg.sv */
package oprl_pkg;

	// ----------------------------------------
	// Port offsets from the base address
	// ----------------------------------------
	localparam logic [1:0] OPRL_OFF_OPTO_LO  = 2'h0;
	localparam logic [1:0] OPRL_OFF_OPTO_HI  = 2'h1;
	localparam logic [1:0] OPRL_OFF_RELAY_LO = 2'h2;
	localparam logic [1:0] OPRL_OFF_RELAY_HI = 2'h3;

	// ----------------------------------------
	// Address decode and reset values
	// ----------------------------------------
	localparam int          OPRL_ADDR_W      = 10;
	localparam int          OPRL_SW_W        = 8;
	localparam logic [9:0]  OPRL_BASE_MIN    = 10'h100;
	localparam logic [9:0]  OPRL_BASE_MAX    = 10'h3fc;
	localparam logic [7:0]  OPRL_RELAY_RST   = 8'h00;
	localparam logic [7:0]  OPRL_IDLE_DATA   = 8'hff;
	localparam int          OPRL_IRQ_LINES   = 6;

	typedef enum logic [1:0] {
		OPRL_ACC_IDLE,
		OPRL_ACC_ACTIVE
	} oprl_acc_t;

endpackage

/* pkg/oprl_dec_if.sv */
`timescale 1ns/1ns
interface oprl_dec_if;
	logic [7:0] base_address_switch;
	logic [9:0] addr;
	logic       hit;
	logic [1:0] offset;

	modport dec  (input base_address_switch, input addr, output hit, output offset);
	modport user (output base_address_switch, output addr, input hit, input offset);
endinterface

/* verilog/oprl_decode.sv */
`timescale 1ns/1ns
module oprl_decode
	import oprl_pkg::*;
(
	oprl_dec_if.dec dif    // Address compare against switch setting
);
	logic [9:0] base_addr;

	// Open switch reads one, closed reads zero; bits A9..A2 compared
	assign base_addr = {dif.base_address_switch, 2'b00};

	always_comb begin
		dif.hit    = (dif.addr[9:2] == base_addr[9:2]) && (base_addr >= OPRL_BASE_MIN)
			&& (base_addr <= OPRL_BASE_MAX);
		dif.offset = dif.addr[1:0];
	end
endmodule

/* verif/oprl_host.sv */
`timescale 1ns/1ns
module oprl_host (
	input  wire logic       core_clk,     // Bus clock
	input  wire logic [7:0] isa_data_out, // Card data
	output logic      [9:0] isa_addr,     // Address
	output logic            isa_ior_n,    // Read strobe
	output logic            isa_iow_n,    // Write strobe
	output logic      [7:0] isa_data_in   // Write data
);
	initial begin
		isa_addr = 10'h000;
		isa_ior_n = 1'b1;
		isa_iow_n = 1'b1;
		isa_data_in = 8'h00;
	end
	task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge core_clk);
		isa_addr <= a;
		isa_data_in <= d;
		isa_ior_n <= w;
		isa_iow_n <= !w;
		repeat (2) @(posedge core_clk);
		q = isa_data_out;
		isa_ior_n <= 1'b1;
		isa_iow_n <= 1'b1;
		// Released lines flip so a stale value cannot pass
		isa_addr <= ~a;
		isa_data_in <= ~d;
	endtask
endmodule

/* verif/oprl_ports_asserts.sv */
`timescale 1ns/1ns
module oprl_ports_asserts (
	input wire logic        core_clk,              // Clock
	input wire logic        reset,                 // Reset
	input wire logic [9:0]  isa_addr,              // Address
	input wire logic        isa_aen,               // DMA cycle
	input wire logic        isa_ior_n,             // Read
	input wire logic        isa_iow_n,             // Write
	input wire logic [7:0]  isa_data_in,           // Write data
	input wire logic [7:0]  isa_data_out,          // Read data
	input wire logic        isa_data_oe,           // Drive enable
	input wire logic [7:0]  base_address_switch,   // Switches
	input wire logic [5:0]  interrupt_line_jumper, // Jumper
	input wire logic [15:0] opto_led_on,           // Inputs
	input wire logic [15:0] relay_energize,        // Relays
	input wire logic [5:0]  isa_irq                // Requests
);
	wire hit = !isa_aen && base_address_switch[7:6] != 2'h0 && isa_addr[9:2] == base_address_switch;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	sequence s_rd; hit && !isa_ior_n; endsequence
	sequence s_wr; hit && !isa_iow_n && $past(isa_iow_n); endsequence
	a_reset_clear: assert property (disable iff (1'b0) reset |=> relay_energize == 16'h0 && !isa_data_oe)
		else $error("relays not cleared by reset");
	a_write_low: assert property (s_wr ##0 isa_addr[1:0] == 2'h2 |=> relay_energize[7:0] == $past(isa_data_in))
		else $error("low relay write lost");
	a_write_high: assert property (s_wr ##0 isa_addr[1:0] == 2'h3 |=> relay_energize[15:8] == $past(isa_data_in))
		else $error("high relay write lost");
	a_relay_hold: assert property (!(hit && !isa_iow_n && $past(isa_iow_n) && isa_addr[1]) |=> $stable(relay_energize))
		else $error("relays changed without write");
	a_read_relay: assert property (s_rd ##0 isa_addr[1] |=> isa_data_oe
		&& isa_data_out == ~($past(isa_addr[0]) ? relay_energize[15:8] : relay_energize[7:0]))
		else $error("relay readback wrong");
	a_read_opto: assert property (s_rd ##0 !isa_addr[1] |=> isa_data_oe
		&& isa_data_out == ~($past(isa_addr[0]) ? $past(opto_led_on[15:8]) : $past(opto_led_on[7:0])))
		else $error("input read wrong");
	a_irq_level: assert property (1'b1 |=> isa_irq == ($past(opto_led_on[0]) ? $past(interrupt_line_jumper) : 6'h0))
		else $error("request line wrong");
	a_idle_bus: assert property (!hit || isa_ior_n |=> !isa_data_oe && isa_data_out == 8'hff)
		else $error("card drove bus unaddressed");
endmodule
bind oprl_ports oprl_ports_asserts ca_u (.*);

/* verif/testbench.sv */
`timescale 1ns/1ns
module testbench;
	logic        core_clk = 1'b0;
	logic        reset = 1'b1;
	logic        isa_aen = 1'b0;
	logic [7:0]  base_address_switch = 8'hc0;
	logic [5:0]  interrupt_line_jumper = 6'h04;
	logic [15:0] opto_led_on = 16'h0000;
	logic [9:0]  isa_addr;
	logic        isa_ior_n;
	logic        isa_iow_n;
	logic        isa_data_oe;
	logic [7:0]  isa_data_in;
	logic [7:0]  isa_data_out;
	logic [7:0]  q;
	logic [15:0] relay_energize;
	logic [5:0]  isa_irq;
	int          errors = 0;
	int          num_checks = 0;
	always #20 core_clk = ~core_clk;
	oprl_ports dut_u (.*);
	oprl_host host_u (.*);
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic complete_run;
		if (errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge core_clk);
		reset <= 1'b0;
		host_u.xfer(1'b0, 10'h300, 8'h00, q);
		chk({isa_irq, q}, 24'h0000ff);
		host_u.xfer(1'b1, 10'h302, 8'h5a, q);
		host_u.xfer(1'b1, 10'h303, 8'hc3, q);
		chk(relay_energize, 24'h00c35a);
		host_u.xfer(1'b0, 10'h303, 8'h00, q);
		chk(q, 24'h00003c);
		host_u.xfer(1'b1, 10'h300, 8'h00, q);
		host_u.xfer(1'b1, 10'h301, 8'h00, q);
		isa_aen <= 1'b1;
		host_u.xfer(1'b1, 10'h302, 8'h00, q);
		chk(relay_energize, 24'h00c35a);
		isa_aen <= 1'b0;
		opto_led_on <= 16'h8001;
		host_u.xfer(1'b0, 10'h300, 8'h00, q);
		chk({isa_irq, q}, 24'h0004fe);
		host_u.xfer(1'b0, 10'h301, 8'h00, q);
		chk(q, 24'h00007f);
		interrupt_line_jumper <= 6'h00;
		base_address_switch <= 8'h40;
		host_u.xfer(1'b1, 10'h102, 8'h11, q);
		chk({isa_irq, relay_energize}, 24'h00c311);
		base_address_switch <= 8'h00;
		host_u.xfer(1'b1, 10'h002, 8'hff, q);
		chk(relay_energize, 24'h00c311);
		reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		chk(relay_energize, 24'h000000);
		complete_run;
	end
endmodule
